// >>> bench/lcg_char_geometry_asserts.sv
// Checker for the character geometry block, bound to its ports
module lcg_char_geometry_asserts (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Configuration
  input wire logic [3:0] char_width_field,
  input wire logic [3:0] char_height_field,
  input wire logic [7:0] line_byte_count,
  input wire logic [7:0] frame_line_value,
  input wire logic       ac_drive_select,
  input wire logic       origin_compensation_flag,
  input wire logic       panel_drive_select,
  input wire logic       graphics_mode,
  input wire logic       frame_end,
  // Derived outputs
  input wire logic [4:0] cell_width,
  input wire logic [4:0] cell_height,
  input wire logic [8:0] line_bytes,
  input wire logic [7:0] first_screen_line_limit,
  input wire logic [7:0] second_screen_line_limit,
  input wire logic       fourth_block_enable,
  input wire logic       text_row_offset,
  input wire logic       dual_panel,
  input wire logic       frame_waveform
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Geometry follows configuration one cycle later
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_width_plain: assert property (!char_width_field[3] && !graphics_mode |=>
    cell_width == $past({1'b0, char_width_field}) + 5'h01) else $error("cell width wrong");
  a_height_plus: assert property (1'b1 |=>
    cell_height == $past({1'b0, char_height_field}) + 5'h01) else $error("cell height wrong");
  a_line_bytes: assert property (line_byte_count <= 8'hEF |=>
    line_bytes == $past({1'b0, line_byte_count}) + 9'h001) else $error("line bytes wrong");
  a_line_clamp: assert property (line_byte_count > 8'hEF |=>
    line_bytes == 9'h0F0) else $error("line bytes not clamped");
  a_dual_limit: assert property (panel_drive_select |=>
    first_screen_line_limit == ($past(frame_line_value) >> 1)
    && second_screen_line_limit == first_screen_line_limit) else $error("dual limit wrong");
  a_single_plain: assert property (!panel_drive_select && origin_compensation_flag |=>
    first_screen_line_limit == $past(frame_line_value)) else $error("single limit wrong");
  a_single_comp: assert property (!panel_drive_select && !origin_compensation_flag
    && frame_line_value != 8'hFF |=> first_screen_line_limit == $past(frame_line_value) + 8'h01)
    else $error("compensated limit wrong");
  a_panel_mode: assert property (1'b1 |=> dual_panel == $past(panel_drive_select)
    && fourth_block_enable == $past(panel_drive_select)) else $error("panel mode wrong");
  a_row_offset: assert property (1'b1 |=>
    text_row_offset == !$past(origin_compensation_flag)) else $error("row offset wrong");
  a_wf_frame: assert property (ac_drive_select && frame_end |=>
    frame_waveform != $past(frame_waveform)) else $error("waveform did not toggle");
  // Main scenarios reached
  c_clamp: cover property (line_byte_count > 8'hEF);
  c_dual: cover property (panel_drive_select && dual_panel);
  c_wf: cover property (ac_drive_select && frame_end);
endmodule : lcg_char_geometry_asserts

bind lcg_char_geometry lcg_char_geometry_asserts u_chk (
  .clock(clock), .rst(rst), .char_width_field(char_width_field),
  .char_height_field(char_height_field), .line_byte_count(line_byte_count),
  .frame_line_value(frame_line_value), .ac_drive_select(ac_drive_select),
  .origin_compensation_flag(origin_compensation_flag),
  .panel_drive_select(panel_drive_select), .graphics_mode(graphics_mode),
  .frame_end(frame_end), .cell_width(cell_width), .cell_height(cell_height),
  .line_bytes(line_bytes), .first_screen_line_limit(first_screen_line_limit),
  .second_screen_line_limit(second_screen_line_limit),
  .fourth_block_enable(fourth_block_enable), .text_row_offset(text_row_offset),
  .dual_panel(dual_panel), .frame_waveform(frame_waveform));

// >>> bench/lcg_char_geometry_tb.sv
// Self-checking testbench for the character geometry block
module lcg_char_geometry_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock, rst, ac_drive_select, origin_compensation_flag, panel_drive_select;
  logic       graphics_mode, font_8_pixel, pixel_tick, line_end, frame_end, run;
  logic [3:0] char_width_field, char_height_field, cell_row;
  logic [7:0] line_byte_count, frame_line_value, pixel_byte, byte_index;
  logic [7:0] first_screen_line_limit, second_screen_line_limit;
  logic [4:0] cell_width, cell_height;
  logic [8:0] line_bytes;
  logic       fourth_block_enable, text_row_offset, dual_panel, pixel_out, pixel_blank;
  logic       byte_fetch, frame_waveform;
  int         num_errors = 0, checked = 0, toggles, t0;
  lcg_char_geometry u_dut (
    .clock(clock), .rst(rst), .char_width_field(char_width_field),
    .char_height_field(char_height_field), .line_byte_count(line_byte_count),
    .frame_line_value(frame_line_value), .ac_drive_select(ac_drive_select),
    .origin_compensation_flag(origin_compensation_flag),
    .panel_drive_select(panel_drive_select), .graphics_mode(graphics_mode),
    .font_8_pixel(font_8_pixel), .pixel_tick(pixel_tick), .line_end(line_end),
    .frame_end(frame_end), .pixel_byte(pixel_byte), .cell_width(cell_width),
    .cell_height(cell_height), .line_bytes(line_bytes),
    .first_screen_line_limit(first_screen_line_limit),
    .second_screen_line_limit(second_screen_line_limit),
    .fourth_block_enable(fourth_block_enable), .text_row_offset(text_row_offset),
    .dual_panel(dual_panel), .pixel_out(pixel_out), .pixel_blank(pixel_blank),
    .byte_fetch(byte_fetch), .byte_index(byte_index), .cell_row(cell_row),
    .frame_waveform(frame_waveform));
  lcg_scan_model u_scan (.clock(clock), .rst(rst), .run(run), .frame_waveform(frame_waveform),
    .line_end(line_end), .frame_end(frame_end), .toggles(toggles));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      num_errors++;
    end
  endtask : check
  task summarize;
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Let the registered outputs follow the new configuration
  task settle;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask : settle
  task automatic lim(input logic p, input logic f, input logic [7:0] fr, input logic [7:0] e);
    @(posedge clock) {panel_drive_select, origin_compensation_flag, frame_line_value}
      <= {p, f, fr};
    settle;
    check("first_limit", first_screen_line_limit, e);
    check("second_limit", second_screen_line_limit, e);
    check("fourth_block", fourth_block_enable, p);
    check("dual_panel", dual_panel, p);
    check("row_offset", text_row_offset, !f);
  endtask : lim
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // One byte per line: the second eight pixels come out blank, eight excess
  // pixels in all; no pixel shift is issued, so the first pixel is column 0
  task t_pixel;
    @(posedge clock) {line_byte_count, pixel_byte} <= {8'h00, 8'hA5};
    repeat (2) @(posedge clock);
    for (int k = 0; k < 16; k++) begin
      pixel_tick <= 1'b1;
      @(posedge clock) pixel_tick <= 1'b0;
      @(negedge clock);
      check("pixel_blank", pixel_blank, 9'(k >= 8));
      if (k < 8) check("pixel_out", pixel_out, 9'(pixel_byte[7 - k]));
      check("byte_fetch", byte_fetch, 9'(k % 8 == 7));
      check("byte_index", byte_index, 9'((k + 1) / 8));
      @(posedge clock);
    end
  endtask : t_pixel
  // Three lines inside one frame with two-pixel-high cells: the row wraps once
  task t_rows;
    @(posedge clock) char_height_field <= 4'h1;
    settle;
    @(posedge clock) run <= 1'b1;
    repeat (12) @(posedge clock);
    run <= 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    check("cell_row", cell_row, 9'h001);
  endtask : t_rows
  task t_geometry;
    for (int i = 0; i < 16; i++) begin
      @(posedge clock) {char_width_field, char_height_field} <= {4'(i & 7), 4'(i)};
      settle;
      check("cell_width", cell_width, 9'((i & 7) + 1));
      check("cell_height", cell_height, 9'(i + 1));
    end
    @(posedge clock) char_width_field <= 4'h9;
    settle;
    check("wide_width", cell_width, 9'h00A);
    @(posedge clock) {char_width_field, font_8_pixel} <= {4'hF, 1'b1};
    settle;
    check("gap_width", cell_width, 9'h009);
    @(posedge clock) {graphics_mode, char_height_field} <= {1'b1, 4'h0};
    settle;
    check("graphic_width", cell_width, 9'h008);
  endtask : t_geometry
  task t_lines;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock) line_byte_count <= (k == 0) ? 8'h00 : (k == 1) ? 8'h4F
        : (k == 2) ? 8'hEF : 8'hF5;
      settle;
      check("line_bytes", line_bytes, (k == 0) ? 9'h001 : (k == 1) ? 9'h050 : 9'h0F0);
    end
  endtask : t_lines
  // Run the scan source for n cycles and compare waveform toggles
  task automatic t_ac(input logic sel, input int n, input int e);
    @(posedge clock) ac_drive_select <= sel;
    settle;
    t0 = toggles;
    @(posedge clock) run <= 1'b1;
    repeat (n) @(posedge clock);
    run <= 1'b0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    check("wf_toggles", 9'(toggles - t0), 9'(e));
  endtask : t_ac
  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    summarize;
  end
  initial begin
    {rst, run, pixel_tick, ac_drive_select, origin_compensation_flag} = 5'b10000;
    {panel_drive_select, graphics_mode, font_8_pixel, pixel_byte} = {3'b000, 8'hFF};
    {char_width_field, char_height_field, line_byte_count, frame_line_value} = 24'h772_73F;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_pixel;
    t_ac(1'b0, 256, 4);
    t_ac(1'b1, 128, 8);
    t_rows;
    t_geometry;
    t_lines;
    lim(1'b0, 1'b1, 8'h3F, 8'h3F);
    lim(1'b0, 1'b0, 8'h3F, 8'h40);
    lim(1'b0, 1'b0, 8'hFF, 8'hFF);
    lim(1'b1, 1'b0, 8'h7F, 8'h3F);
    lim(1'b1, 1'b1, 8'h7F, 8'h3F);
    summarize;
  end
endmodule : lcg_char_geometry_tb

// >>> bench/lcg_scan_model.sv
// Scan timing source and waveform watcher standing in for the panel side
module lcg_scan_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control and observed waveform
  input  wire logic run,
  input  wire logic frame_waveform,
  // Scan pulses and toggle count
  output logic      line_end,
  output logic      frame_end,
  output int        toggles
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cyc;
  logic [1:0] ln;
  logic       last_wf;
  // Four cycles a line, four lines a frame; frame end shares the last line end
  always_ff @(posedge clock) begin
    cyc       <= (rst || !run) ? 2'h0 : cyc + 2'h1;
    line_end  <= run && cyc == 2'h3;
    frame_end <= run && cyc == 2'h3 && ln == 2'h3;
    if (rst) begin
      ln <= 2'h0;
    end else if (run && cyc == 2'h3) begin
      ln <= ln + 2'h1;
    end
    last_wf <= frame_waveform;
    if (rst) begin
      toggles <= 0;
    end else begin
      toggles <= toggles + int'(last_wf !== frame_waveform);
    end
  end
endmodule : lcg_scan_model

// >>> verilog/lcg_char_geometry.sv
// Character cell geometry, line length, AC drive and screen line limits
// What this block does
// - Cell width is width field plus one, for 00 to 07H.
// - Width bit 3 set with an 8-pixel font inserts a blank between characters.
// - Wider cells use 8-pixel byte segments; second byte remainder is blank.
// - Graphics mode uses eight-pixel cells; wider remainder in second byte not shown.
// - AC select clear toggles the frame waveform every 16 scan lines.
// - AC select set gives frame waveform period of two frames.
// - Cell height is height field plus one, 1 to 16 pixels.
// - Line byte count 0 to 239 means 1 to 240 bytes per line.
// - Bytes beyond the programmed count on a line are shown blank.
// - Compensation flag 0 shifts text down one pixel; flag 1 no shift.
// - Single panel limits run 00H to frame value, plus one with compensation.
// - Panel select 0 is single-panel, 1 is dual-panel.
module lcg_char_geometry (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // Configuration from the command decoder
  input  wire logic [lcg_pkg::CELL_FIELD_W-1:0] char_width_field,
  input  wire logic [lcg_pkg::CELL_FIELD_W-1:0] char_height_field,
  input  wire logic [lcg_pkg::BYTE_FIELD_W-1:0] line_byte_count,
  input  wire logic [lcg_pkg::BYTE_FIELD_W-1:0] frame_line_value,
  input  wire logic                    ac_drive_select,
  input  wire logic                    origin_compensation_flag,
  input  wire logic                    panel_drive_select,
  input  wire logic                    graphics_mode,
  input  wire logic                    font_8_pixel,
  // Scan timing from the neighbouring line generator
  input  wire logic                    pixel_tick,
  input  wire logic                    line_end,
  input  wire logic                    frame_end,
  // Pixel data from display memory, one byte per segment
  input  wire logic [7:0]              pixel_byte,
  // Derived geometry
  output logic [4:0]                   cell_width,
  output logic [4:0]                   cell_height,
  output logic [8:0]                   line_bytes,
  output logic [7:0]                   first_screen_line_limit,
  output logic [7:0]                   second_screen_line_limit,
  output logic                         fourth_block_enable,
  output logic                         text_row_offset,
  output logic                         dual_panel,
  // Pixel stream
  output logic                         pixel_out,
  output logic                         pixel_blank,
  output logic                         byte_fetch,
  output logic [7:0]                   byte_index,
  output logic [3:0]                   cell_row,
  output logic                         frame_waveform
);
  import lcg_pkg::*;

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  logic       space_en;
  logic [3:0] width_eff;
  logic [3:0] height_eff;
  logic [7:0] line_max;

  // Clamp helper keeps the line byte count inside its legal range
  // A count above the top of the range is refused by holding it at the top,
  // so a bad parameter cannot show bytes past the last column.
  function automatic logic [7:0] clamp_line(input logic [7:0] v);
    clamp_line = (v > LINE_BYTES_MAX) ? LINE_BYTES_MAX : v;
  endfunction : clamp_line

  // Graphics mode forces eight-pixel cells, text uses the field directly unless the gap is enabled
  always_comb begin
    // The gap is a text feature; graphics cells stay exactly one byte wide
    space_en   = ((char_width_field & WIDTH_SPACE_BIT_MASK) != 4'h0) && font_8_pixel
                 && !graphics_mode;
    if (graphics_mode) begin
      width_eff = WIDTH_PIX_MASK;
    end else if (space_en) begin
      width_eff = WIDTH_PIX_MASK;
    end else begin
      width_eff = char_width_field;
    end
    height_eff = char_height_field;
    line_max   = clamp_line(line_byte_count);
  end

  // ---------------------------------------------------------------
  // Registered geometry outputs
  // ---------------------------------------------------------------
  logic [4:0] next_cell_width;
  logic [4:0] next_cell_height;
  logic [8:0] next_line_bytes;
  logic [7:0] next_sl1;
  logic [7:0] next_sl2;
  logic       next_fourth_block_start_address;
  logic       next_offset;
  logic       next_dual;

  // Screen limits depend on panel mode and compensation
  // In dual-panel drive each half scans half the frame; an odd frame value
  // rounds down, so the host keeps the frame line count even in that mode.
  always_comb begin
    next_cell_width  = {1'b0, width_eff} + 5'h01 + {4'h0, space_en};
    next_cell_height = {1'b0, height_eff} + 5'h01;
    next_line_bytes  = {1'b0, line_max} + 9'h001;
    next_dual        = panel_drive_select;
    if (panel_drive_select) begin
      next_sl1  = {1'b0, frame_line_value[7:1]};
      next_sl2  = {1'b0, frame_line_value[7:1]};
      next_fourth_block_start_address = 1'b1;
    end else begin
      // Saturate so an FFH frame value does not wrap to zero
      if (!origin_compensation_flag && frame_line_value != 8'hFF) begin
        next_sl1 = frame_line_value + 8'h01;
      end else begin
        next_sl1 = frame_line_value;
      end
      next_sl2  = next_sl1;
      next_fourth_block_start_address = 1'b0;
    end
    next_offset = ~origin_compensation_flag;
  end

  // Geometry registers; reset shows the power-on character layout, and every clock
  // after reset loads the layout decoded from the configuration inputs
  always_ff @(posedge clock) begin
    if (rst) begin
      cell_width               <= {1'b0, WIDTH_RESET} + 5'h01;
      cell_height              <= {1'b0, HEIGHT_RESET} + 5'h01;
      line_bytes               <= {1'b0, LINE_RESET} + 9'h001;
      first_screen_line_limit  <= FRAME_RESET;
      second_screen_line_limit <= FRAME_RESET;
      fourth_block_enable      <= 1'b0;
      text_row_offset          <= 1'b0;
      dual_panel               <= 1'b0;
    end else begin
      cell_width               <= next_cell_width;
      cell_height              <= next_cell_height;
      line_bytes               <= next_line_bytes;
      first_screen_line_limit  <= next_sl1;
      second_screen_line_limit <= next_sl2;
      fourth_block_enable      <= next_fourth_block_start_address;
      text_row_offset          <= next_offset;
      dual_panel               <= next_dual;
    end
  end

  // ---------------------------------------------------------------
  // Horizontal pixel walk through cells and byte segments
  // ---------------------------------------------------------------
  // Segment, column and byte counters of the pixel walk; the column counts
  // pixels inside the current byte, not inside the whole cell
  lcg_seg_t   seg;
  lcg_seg_t   next_seg;
  logic [3:0] col;
  logic [3:0] next_col;
  logic [7:0] bidx;
  logic [7:0] next_bidx;
  logic       next_pixel;
  logic       next_blank;
  logic       next_fetch;
  logic       wide;
  logic [3:0] seg_last;

  // A cell wider than a byte spans two segments; tail of the second is blank
  // Line end restarts the walk at the first byte and asks for a fresh fetch,
  // so a line cut short never carries a half-drawn cell into the next one.
  // Memory delivers one byte per fetch, leftmost pixel in the top bit.
  always_comb begin
    wide       = (width_eff >= SEG_PIXELS) && !graphics_mode;
    seg_last   = wide ? WIDTH_PIX_MASK : width_eff;
    next_seg   = seg;
    next_col   = col;
    next_bidx  = bidx;
    next_fetch = 1'b0;
    next_blank = 1'b0;
    next_pixel = pixel_out;
    if (line_end) begin
      next_seg   = LCG_SEG_FIRST;
      next_col   = 4'h0;
      next_bidx  = 8'h00;
      next_fetch = 1'b1;
      next_pixel = 1'b0;
      next_blank = 1'b1;
    end else if (pixel_tick) begin
      // Bytes past the programmed count are blanked
      // A blanked pixel is forced low below, so blank slots never leak data
      next_blank = (bidx > line_max);
      case (seg)
        LCG_SEG_FIRST: begin
          next_pixel = pixel_byte[3'(WIDTH_PIX_MASK - col)];
        end
        LCG_SEG_SECOND: begin
          next_pixel = pixel_byte[3'(WIDTH_PIX_MASK - col)];
          if (col > (width_eff - SEG_PIXELS)) begin
            next_blank = 1'b1;
          end
        end
        LCG_SEG_GAP: begin
          next_blank = 1'b1;
        end
        default: begin
          next_blank = 1'b1;
        end
      endcase
      if (next_blank) begin
        next_pixel = 1'b0;
      end
      if (seg == LCG_SEG_GAP) begin
        next_seg = LCG_SEG_FIRST;
        next_col = 4'h0;
      end else if (col == seg_last || col == WIDTH_PIX_MASK) begin
        next_col   = 4'h0;
        next_fetch = 1'b1;
        next_bidx  = bidx + 8'h01;
        if (seg == LCG_SEG_FIRST && wide) begin
          next_seg = LCG_SEG_SECOND;
        end else if (space_en && !graphics_mode) begin
          next_seg = LCG_SEG_GAP;
        end else begin
          next_seg = LCG_SEG_FIRST;
        end
      end else begin
        next_col = col + 4'h1;
      end
    end
  end

  // Pixel walk registers; the blank flag starts high in reset, but any cycle
  // with neither a line end nor a pixel tick clears it again
  always_ff @(posedge clock) begin
    if (rst) begin
      seg         <= LCG_SEG_FIRST;
      col         <= 4'h0;
      bidx        <= 8'h00;
      pixel_out   <= 1'b0;
      pixel_blank <= 1'b1;
      byte_fetch  <= 1'b0;
    end else begin
      seg         <= next_seg;
      col         <= next_col;
      bidx        <= next_bidx;
      pixel_out   <= next_pixel;
      pixel_blank <= next_blank;
      byte_fetch  <= next_fetch;
    end
  end

  // The byte counter is a register, so the index leaves straight from it
  assign byte_index = bidx;

  // ---------------------------------------------------------------
  // Vertical cell row and AC frame waveform
  // ---------------------------------------------------------------
  logic [3:0] row;
  logic [3:0] next_row;
  logic [3:0] ac_cnt;
  logic [3:0] next_ac_cnt;
  logic       next_wf;

  // Two-frame drive flips once per frame, giving a two-frame period.
  // The 16-line counter holds still in that mode, so switching back resumes
  // the line count where it stopped instead of restarting it.
  // Frame end wins over line end for the row, so every frame opens on the
  // top pixel row of its first character line.
  always_comb begin
    next_row       = row;
    next_ac_cnt    = ac_cnt;
    next_wf        = frame_waveform;
    if (frame_end) begin
      next_row       = 4'h0;
      if (ac_drive_select) begin
        next_wf = ~frame_waveform;
      end
    end else if (line_end) begin
      next_row = (row >= height_eff) ? 4'h0 : row + 4'h1;
    end
    if (line_end && !ac_drive_select) begin
      if (ac_cnt == AC_LINES) begin
        next_ac_cnt = 4'h0;
        next_wf     = ~frame_waveform;
      end else begin
        next_ac_cnt = ac_cnt + 4'h1;
      end
    end
  end

  // Row and waveform registers; the waveform starts low out of reset
  // so the drivers see a known polarity on the first frame
  always_ff @(posedge clock) begin
    if (rst) begin
      row            <= 4'h0;
      ac_cnt         <= 4'h0;
      frame_waveform <= 1'b0;
    end else begin
      row            <= next_row;
      ac_cnt         <= next_ac_cnt;
      frame_waveform <= next_wf;
    end
  end

  // The row counter is a register as well, so the output needs no extra stage
  assign cell_row = row;

endmodule : lcg_char_geometry

// >>> verilog/lcg_pkg.sv
// Package of constants for the character geometry configuration block
package lcg_pkg;
  // ---------------------------------------------------------------
  // Field widths and limits
  // ---------------------------------------------------------------
  localparam int unsigned CELL_FIELD_W   = 4;
  localparam int unsigned BYTE_FIELD_W   = 8;
  localparam logic [7:0]  LINE_BYTES_MAX = 8'hEF;   // 240 bytes per line
  localparam logic [3:0]  WIDTH_SPACE_BIT_MASK = 4'h8;
  localparam logic [3:0]  WIDTH_PIX_MASK = 4'h7;
  localparam logic [3:0]  SEG_PIXELS     = 4'h8;    // Display data handled a byte at a time
  localparam logic [3:0]  AC_LINES       = 4'hF;    // Last line index of a 16-line AC period
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  WIDTH_RESET    = 4'h7;
  localparam logic [3:0]  HEIGHT_RESET   = 4'h7;
  localparam logic [7:0]  LINE_RESET     = 8'h27;
  localparam logic [7:0]  FRAME_RESET    = 8'h3F;
  // Horizontal pixel phase within a cell
  typedef enum logic [1:0] {LCG_SEG_FIRST, LCG_SEG_SECOND, LCG_SEG_GAP} lcg_seg_t;
endpackage : lcg_pkg
